/* File: dv/testbench.sv */
// scenario bench for the trim, offset, phase floor and retry block
// assumes the host model for bus cycles and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module testbench;
    logic clk = 0, nrst = 0, cyc, we, ack, irq, ocMask, faultFlag, retryStart, faultIn = 0;
    logic dvcActive = 0, dvcRise = 0, dvcFast = 0, vinValid = 0, imonValid = 0;
    logic [17:0] adr;
    logic [31:0] dat, rdat;
    logic [15:0] vinRaw = 0, vinCorr, ioutCorr;
    logic [11:0] imonRaw = 0, imonCorr;
    logic [8:0] ioutFullScale;
    logic [2:0] lowPowerPhases;
    logic signed [20:0] refOffset;
    int n_errors = 0, num_checks = 0, cnt;
    int ex[4] = '{-2, -1, 2, 1};
    // short hiccup wait keeps the run brief
    vr_trim_and_dynamic_voltage_change_offset_config #(.HICCUP_CYCLES(20)) dut (.clk, .nrst, .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq, .dvcActive, .dvcRise,
        .dvcFast, .refOffset, .ocMask, .vinValid, .vinRaw, .vinCorr, .imonValid, .imonRaw,
        .imonCorr, .ioutValid(vinValid), .ioutRaw(vinRaw), .tempDelta(8'h0), .ioutCorr,
        .ioutFullScale, .lowPowerPhases, .faultIn, .faultFlag, .retryStart);
    wb_host host (.clk, .cyc, .we, .adr, .dat, .ack, .rdat);
    always #25 clk = ~clk;
    task automatic wr(input logic [15:0] i, input logic [31:0] d);
        host.xfer(1'b1, i, d);
    endtask
    task automatic rc(input string n, input logic [15:0] i, input logic [31:0] e);
        host.xfer(1'b0, i, 32'h0);
        `CHK(n, e, host.q)
    endtask
    task automatic strobe;
        vinValid <= 1'b1;
        imonValid <= 1'b1;
        @(posedge clk);
        vinValid <= 1'b0;
        imonValid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_regs;
        rc("vgain", vr_trim_pkg::IDX_VIN_GAIN, 32'h80);
        wr(vr_trim_pkg::IDX_FSR, 32'h1FF);
        rc("fsr", vr_trim_pkg::IDX_FSR, 32'h1FF);
        `CHK("fsr port", 9'h1FF, ioutFullScale)
        rc("hole", 16'h0123, 32'h0);
    endtask
    task automatic t_phase;
        wr(vr_trim_pkg::IDX_MASK, 32'h8);
        wr(vr_trim_pkg::IDX_LP, 32'h7);
        rc("status", vr_trim_pkg::IDX_STATUS, 32'h8);
        `CHK("irq", 1'b1, irq)
        `CHK("kept", 3'h1, lowPowerPhases)
        wr(vr_trim_pkg::IDX_STATUS, 32'h8);
        wr(vr_trim_pkg::IDX_LP, 32'h6);
        repeat (2) @(posedge clk);
        `CHK("irq off", 1'b0, irq)
        `CHK("phases", 3'h6, lowPowerPhases)
    endtask
    task automatic t_dvc;
        // offsets +1, +2, -1, -2 steps; tau 0; mask count 3 gives 7 cycles
        wr(vr_trim_pkg::IDX_DVC_HI, 32'h042F);
        wr(vr_trim_pkg::IDX_DVC_LO, 32'hFE00_0003);
        repeat (25) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            dvcRise <= i[1];
            dvcFast <= i[0];
            dvcActive <= 1'b1;
            repeat (4) @(posedge clk);
            `CHK("offset", ex[i] * 16384, refOffset)
            dvcActive <= 1'b0;
            cnt = 0;
            repeat (12) begin
                @(posedge clk);
                cnt += ocMask;
            end
            `CHK("mask", 7, cnt)
        end
    endtask
    task automatic t_tele;
        rc("igain", vr_trim_pkg::IDX_CURRENT_MONITOR_GAIN, 32'h80);
        wr(vr_trim_pkg::IDX_CTRL, 32'h1);
        wr(vr_trim_pkg::IDX_VIN_GAIN, 32'h40);
        wr(vr_trim_pkg::IDX_CURRENT_MONITOR_GAIN, 32'h40);
        vinRaw <= 16'd1000;
        imonRaw <= 12'h800;
        strobe();
        `CHK("vin", 16'd500, vinCorr)
        `CHK("current_monitor", 12'h400, imonCorr)
        wr(vr_trim_pkg::IDX_VIN_GAIN, 32'h80);
        wr(vr_trim_pkg::IDX_VIN_OFS, 32'h003);
        strobe();
        `CHK("vin ofs", 16'd997, vinCorr)
        wr(vr_trim_pkg::IDX_CTRL, 32'h3);
        rc("stored", vr_trim_pkg::IDX_STORED, 32'h40);
    endtask
    task automatic t_retry;
        wr(vr_trim_pkg::IDX_LP, 32'h86);
        faultIn <= 1'b1;
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (retryStart !== 1'b1 && cnt < 40);
        `CHK("wait", 1'b1, cnt inside {[21:23]})
        `CHK("flag", 1'b0, faultFlag)
        faultIn <= 1'b0;
        `CHK("iout", 1000, ioutCorr)
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_phase();
        t_dvc();
        t_tele();
        t_retry();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule // testbench
bind vr_trim_and_dynamic_voltage_change_offset_config vr_trim_monitor mon (.clk, .nrst, .wb_we_i, .wb_dat_o,
    .wb_ack_o, .dvcActive, .ocMask, .vinValid, .vinCorr, .lowPowerPhases, .faultFlag,
    .retryStart);
`default_nettype wire

/* File: dv/vr_trim_monitor.sv */
// port-level checks for the trim and transition-offset block
// assumes binding onto the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module vr_trim_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic dvcActive,
    input wire logic ocMask,
    input wire logic vinValid,
    input wire logic [15:0] vinCorr,
    input wire logic [2:0] lowPowerPhases,
    input wire logic faultFlag,
    input wire logic retryStart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat");
    AST_MASK_GO: assert property ($fell(dvcActive) |=> ocMask) else $error("no mask");
    AST_PH_RANGE: assert property (lowPowerPhases inside {[1:6]}) else $error("ph");
    AST_PH_HOLD: assert property ($changed(lowPowerPhases) |-> $past(wb_we_i) ||
        $past(wb_we_i, 2)) else $error("ph moved");
    AST_VIN_SRC: assert property ($changed(vinCorr) |-> $past(vinValid)) else $error("vin");
    AST_RT_PULSE: assert property (retryStart |=> !retryStart) else $error("rt");
    AST_RT_CLR: assert property (retryStart |-> !faultFlag) else $error("flag");
    cover property ($rose(ocMask));
    cover property (retryStart);
    cover property (wb_ack_o && wb_we_i);
endmodule // vr_trim_monitor
`default_nettype wire

/* File: dv/wb_host.sv */
// configuration host model on the classic wishbone port
// assumes one clock; the bench calls xfer, stb is tied to cyc
`timescale 1ns/1ps
`default_nettype none
module wb_host (
    input wire logic clk,
    output logic cyc,
    output logic we,
    output logic [17:0] adr,
    output logic [31:0] dat,
    input wire logic ack,
    input wire logic [31:0] rdat
);
    logic [31:0] q;
    initial {cyc, we, adr, dat} = '0;
    task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= d;
        // no latency assumed; the bench watchdog ends a hang
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask
endmodule // wb_host
`default_nettype wire

/* File: rtl/div_if.sv */
// request/answer bundle between the control block and a sequential divider
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface div_if #(parameter int NW = 8, parameter int DW = 8);
    logic start;
    logic [NW-1:0] num;
    logic [DW-1:0] den;
    logic busy;
    logic done;
    logic [NW-1:0] quot;
    modport master (output start, output num, output den, input busy, input done, input quot);
    modport slave (input start, input num, input den, output busy, output done, output quot);
endinterface
`default_nettype wire

/* File: rtl/seq_divider.sv */
// restoring unsigned divider, one quotient bit per enabled clock
// assumes start only while not busy; done pulses one cycle with quot valid
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
    parameter int NW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    div_if.slave d
);
    localparam int CW = $clog2(NW + 1);
    logic [DW:0] rem_q;
    logic [DW-1:0] den_q;
    logic [NW-1:0] num_q;
    logic [NW-1:0] quo_q;
    logic [CW-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire [DW:0] trial = {rem_q[DW-1:0], num_q[NW-1]};
    wire fits = trial >= {1'b0, den_q};
    wire [DW:0] remNext = fits ? trial - {1'b0, den_q} : trial;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rem_q <= '0;
            den_q <= '0;
            num_q <= '0;
            quo_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= busy_q && cnt_q == CW'(1);
            if (d.start && !busy_q) begin
                rem_q <= '0;
                den_q <= d.den;
                num_q <= d.num;
                cnt_q <= CW'(NW);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q <= remNext;
                num_q <= {num_q[NW-2:0], 1'b0};
                quo_q <= {quo_q[NW-2:0], fits};
                cnt_q <= cnt_q - CW'(1);
                busy_q <= cnt_q != CW'(1);
            end
        end
    end

    assign d.busy = busy_q;
    assign d.done = done_q;
    assign d.quot = quo_q;
endmodule // seq_divider
`default_nettype wire

/* File: rtl/vr_trim_and_dynamic_voltage_change_offset_config.sv */
// transition offset filter, overcurrent mask, telemetry trims, phase floor, retry
// assumes a classic wishbone master, inputs synchronous to clk, word-indexed map
// Behaviour
// (R01) four signed 6-bit transition offsets, 5 mV steps
// (R02) add matching offset to reference during transition
// (R03) offset applied through first-order filter, derived coefficient
// (R04) mask overcurrent after transition: n*100ns+25ns
// (R05) opto mode: scale vin by gain/128
// (R06) host programs 0x80 for 1/40 divider
// (R07) divide iout by thermal correction term
// (R08) correction bounded 0.67..1.0, delta clamped
// (R09) 9-bit current monitor full scale field
// (R10) vin offset bit 10 set adds, clear subtracts
// (R11) opto mode: vin offset in 0.125 V steps
// (R12) current monitor reading scaled by gain/128
// (R13) startup loads working gain from stored copy+trim
// (R14) store command saves modified gain minus trim
// (R15) low power keeps 1..6 phases minimum
// (R16) hiccup bit retries startup 1 ms after fault
// (R17) hiccup restart clears the fault flag
// (R18) fields retained; unsupported codes leave state unchanged
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vr_trim_and_dynamic_voltage_change_offset_config #(
    parameter int HICCUP_CYCLES = vr_trim_pkg::HICCUP_CYC,
    parameter int VIN_W = 16,
    parameter int CURRENT_MONITOR_W = 12,
    parameter int IOUT_W = 16,
    parameter logic signed [7:0] FACTORY_TRIM = 8'sh00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [vr_trim_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic dvcActive,
    input wire logic dvcRise,
    input wire logic dvcFast,
    output logic signed [20:0] refOffset,
    output logic ocMask,
    input wire logic vinValid,
    input wire logic [VIN_W-1:0] vinRaw,
    output logic [VIN_W-1:0] vinCorr,
    input wire logic imonValid,
    input wire logic [CURRENT_MONITOR_W-1:0] imonRaw,
    output logic [CURRENT_MONITOR_W-1:0] imonCorr,
    input wire logic ioutValid,
    input wire logic [IOUT_W-1:0] ioutRaw,
    input wire logic [7:0] tempDelta,
    output logic [IOUT_W-1:0] ioutCorr,
    output logic [8:0] ioutFullScale,
    output logic [2:0] lowPowerPhases,
    input wire logic faultIn,
    output logic faultFlag,
    output logic retryStart
);
    localparam int HW = $clog2(HICCUP_CYCLES + 1);
    localparam int TNW = IOUT_W + 21;
    localparam int TDW = 22;

    typedef enum logic [1:0] {RUN, WAIT_RETRY} retry_e;

    // register file
    logic [47:0] dvc_q;
    logic [7:0] vinGain_q;
    logic [7:0] therm_q;
    logic [8:0] fsr_q;
    logic [10:0] vinOfs_q;
    logic [7:0] imonGain_q;
    logic [7:0] lp_q;
    logic optoMode_q;
    logic [vr_trim_pkg::EV_W-1:0] status_q;
    logic [vr_trim_pkg::EV_W-1:0] mask_q;
    logic [7:0] storedGain_q;
    logic gainDirty_q;
    logic loadPend_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic irq_q;

    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // bus decode
    wire [15:0] idx = wb_adr_i[vr_trim_pkg::ADR_W-1:2];
    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = req && wb_we_i;
    wire hitDvcLo = idx == vr_trim_pkg::IDX_DVC_LO;
    wire hitDvcHi = idx == vr_trim_pkg::IDX_DVC_HI;
    wire hitVinGain = idx == vr_trim_pkg::IDX_VIN_GAIN;
    wire hitTherm = idx == vr_trim_pkg::IDX_THERM;
    wire hitFsr = idx == vr_trim_pkg::IDX_FSR;
    wire hitVinOfs = idx == vr_trim_pkg::IDX_VIN_OFS;
    wire hitImonGain = idx == vr_trim_pkg::IDX_CURRENT_MONITOR_GAIN;
    wire hitLp = idx == vr_trim_pkg::IDX_LP;
    wire hitCtrl = idx == vr_trim_pkg::IDX_CTRL;
    wire hitStatus = idx == vr_trim_pkg::IDX_STATUS;
    wire hitMask = idx == vr_trim_pkg::IDX_MASK;
    wire hitStored = idx == vr_trim_pkg::IDX_STORED;
    wire hitCoef = idx == vr_trim_pkg::IDX_COEF;
    wire [31:0] ctrlWord = {31'h0000_0000, optoMode_q};
    logic [vr_trim_pkg::COEF_W-1:0] coef_q;

    wire [31:0] dvcLoNew = laneMerge(dvc_q[31:0], wb_dat_i, wb_sel_i);
    wire [31:0] dvcHiNew = laneMerge({16'h0000, dvc_q[47:32]}, wb_dat_i, wb_sel_i);
    wire [31:0] vinGainNew = laneMerge({24'h000000, vinGain_q}, wb_dat_i, wb_sel_i);
    wire [31:0] thermNew = laneMerge({24'h000000, therm_q}, wb_dat_i, wb_sel_i);
    wire [31:0] fsrNew = laneMerge({23'h000000, fsr_q}, wb_dat_i, wb_sel_i);
    wire [31:0] vinOfsNew = laneMerge({21'h000000, vinOfs_q}, wb_dat_i, wb_sel_i);
    wire [31:0] imonGainNew = laneMerge({24'h000000, imonGain_q}, wb_dat_i, wb_sel_i);
    wire [31:0] lpNew = laneMerge({24'h000000, lp_q}, wb_dat_i, wb_sel_i);
    wire [31:0] ctrlNew = laneMerge(ctrlWord, wb_dat_i, wb_sel_i);
    wire [31:0] clrWord = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
    wire [31:0] maskNew = laneMerge({28'h0000000, mask_q}, wb_dat_i, wb_sel_i);
    wire wrTau = wr && (hitDvcLo || hitDvcHi);
    wire storeCmd = wr && hitCtrl && ctrlNew[vr_trim_pkg::CTRL_STORE_BIT];
    wire [2:0] phaseNew = lpNew[vr_trim_pkg::LP_PHASE_W-1:0];
    wire phaseOk = phaseNew >= vr_trim_pkg::PHASE_MIN && phaseNew <= vr_trim_pkg::PHASE_MAX;
    wire badPhase = wr && hitLp && !phaseOk;

    wire [31:0] rdMux =
        hitDvcLo ? dvc_q[31:0] :
        hitDvcHi ? {16'h0000, dvc_q[47:32]} :
        hitVinGain ? {24'h000000, vinGain_q} :
        hitTherm ? {24'h000000, therm_q} :
        hitFsr ? {23'h000000, fsr_q} :
        hitVinOfs ? {21'h000000, vinOfs_q} :
        hitImonGain ? {24'h000000, imonGain_q} :
        hitLp ? {24'h000000, lp_q} :
        hitCtrl ? ctrlWord :
        hitStatus ? {28'h0000000, status_q} :
        hitMask ? {28'h0000000, mask_q} :
        hitStored ? {24'h000000, storedGain_q} :
        hitCoef ? {17'h00000, coef_q} : 32'h0000_0000;

    // transition offset selection and filter
    logic signed [20:0] filt_q;
    logic dvcPrev_q;
    logic [vr_trim_pkg::MASK_CNT_W-1:0] maskCnt_q;
    logic [vr_trim_pkg::EV_W-1:0] events;
    wire [5:0] ofsRiseFast = dvc_q[vr_trim_pkg::RISE_FAST_LSB +: vr_trim_pkg::OFS_W];
    wire [5:0] ofsRiseSlow = dvc_q[vr_trim_pkg::RISE_SLOW_LSB +: vr_trim_pkg::OFS_W];
    wire [5:0] ofsFallFast = dvc_q[vr_trim_pkg::FALL_FAST_LSB +: vr_trim_pkg::OFS_W];
    wire [5:0] ofsFallSlow = dvc_q[vr_trim_pkg::FALL_SLOW_LSB +: vr_trim_pkg::OFS_W];
    wire [5:0] ofsPick = dvcRise ? (dvcFast ? ofsRiseFast : ofsRiseSlow) // R01
                                 : (dvcFast ? ofsFallFast : ofsFallSlow);
    // target falls back to zero when no transition runs, so removal uses the same filter
    wire signed [20:0] target = dvcActive ? // R02
        {{1{ofsPick[5]}}, ofsPick, 14'h0000} : 21'sh000000;
    wire signed [21:0] diff = 22'(target) - 22'(filt_q);
    wire signed [37:0] prod = diff * $signed({1'b0, coef_q});
    wire signed [20:0] stepVal = 21'(prod >>> vr_trim_pkg::COEF_FRAC);
    wire [vr_trim_pkg::TAU_W-1:0] tau = dvc_q[vr_trim_pkg::TAU_LSB +: vr_trim_pkg::TAU_W];
    wire [vr_trim_pkg::OCM_W-1:0] ocmField = dvc_q[vr_trim_pkg::OCM_LSB +: vr_trim_pkg::OCM_W];
    wire [31:0] maskNs = 32'(ocmField) * 32'(vr_trim_pkg::MASK_STEP_NS)
                         + 32'(vr_trim_pkg::MASK_FIXED_NS);
    // least time, so round up to whole clocks
    wire [vr_trim_pkg::MASK_CNT_W-1:0] maskCyc = vr_trim_pkg::MASK_CNT_W'(
        (maskNs + 32'(vr_trim_pkg::CLK_NS - 1)) / 32'(vr_trim_pkg::CLK_NS));
    wire dvcEnd = dvcPrev_q && !dvcActive;

    // coefficient divider: 25*2^14 / (25 + tau)
    div_if #(.NW(19), .DW(15)) coefBus ();
    logic coefPend_q;
    logic coefStart_q;
    assign coefBus.start = coefStart_q;
    assign coefBus.num = 19'(vr_trim_pkg::COEF_NUM);
    assign coefBus.den = 15'(vr_trim_pkg::COEF_BASE_NS) + 15'(tau);
    seq_divider #(.NW(19), .DW(15)) coefDiv (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(coefBus)
    );

    // thermal correction divider: iout*base / (base + 39*dT*gain)
    div_if #(.NW(TNW), .DW(TDW)) thermBus ();
    logic thermStart_q;
    logic [TNW-1:0] thermNum_q;
    logic [TDW-1:0] thermDen_q;
    wire [15:0] tProd = 16'(tempDelta) * 16'(therm_q);
    // bounding the product caps the correction at its documented floor
    wire [15:0] tClamp = tProd > 16'(vr_trim_pkg::THERM_PROD_MAX) ? // R08
        16'(vr_trim_pkg::THERM_PROD_MAX) : tProd;
    assign thermBus.start = thermStart_q;
    assign thermBus.num = thermNum_q;
    assign thermBus.den = thermDen_q;
    seq_divider #(.NW(TNW), .DW(TDW)) thermDiv (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .d(thermBus)
    );

    // telemetry arithmetic
    wire [VIN_W+7:0] vinScaled = (VIN_W + 8)'(vinRaw) * (VIN_W + 8)'(vinGain_q);
    wire [VIN_W+1:0] vinGained = (VIN_W + 2)'(vinScaled >> vr_trim_pkg::GAIN_SHIFT);
    wire [VIN_W+1:0] vinMag = (VIN_W + 2)'(vinOfs_q[vr_trim_pkg::VIN_MAG_W-1:0]);
    wire vinAdd = vinOfs_q[vr_trim_pkg::VIN_SIGN_BIT];
    wire [VIN_W+1:0] vinSum = vinAdd ? vinGained + vinMag : // R10
        (vinGained > vinMag ? vinGained - vinMag : '0);
    wire [VIN_W-1:0] vinSat = |vinSum[VIN_W+1:VIN_W] ? '1 : vinSum[VIN_W-1:0];
    wire [CURRENT_MONITOR_W+7:0] imScaled = (CURRENT_MONITOR_W + 8)'(imonRaw) * (CURRENT_MONITOR_W + 8)'(imonGain_q);
    wire [CURRENT_MONITOR_W:0] imGained = (CURRENT_MONITOR_W + 1)'(imScaled >> vr_trim_pkg::GAIN_SHIFT);
    wire [CURRENT_MONITOR_W-1:0] imSat = imGained[CURRENT_MONITOR_W] ? '1 : imGained[CURRENT_MONITOR_W-1:0];

    // retry sequencing
    retry_e retry_q;
    logic [HW-1:0] retryCnt_q;
    logic faultPrev_q;
    wire hiccupOn = lp_q[vr_trim_pkg::LP_HICCUP_BIT];
    wire faultRise = faultIn && !faultPrev_q;
    wire retryFire = retry_q == WAIT_RETRY && retryCnt_q == HW'(1);

    assign events[vr_trim_pkg::EV_DVC_END] = dvcEnd;
    assign events[vr_trim_pkg::EV_RETRY] = retryFire;
    assign events[vr_trim_pkg::EV_STORED] = storeCmd && gainDirty_q;
    assign events[vr_trim_pkg::EV_BAD_PHASE] = badPhase;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dvc_q <= vr_trim_pkg::RST_DVC;
            vinGain_q <= vr_trim_pkg::RST_VIN_GAIN;
            therm_q <= vr_trim_pkg::RST_THERM;
            fsr_q <= vr_trim_pkg::RST_FSR;
            vinOfs_q <= vr_trim_pkg::RST_VIN_OFS;
            lp_q <= vr_trim_pkg::RST_LP;
            optoMode_q <= 1'b0;
            mask_q <= '0;
        end else if (ce && wr) begin
            if (hitDvcLo) dvc_q[31:0] <= dvcLoNew;
            if (hitDvcHi) dvc_q[47:32] <= dvcHiNew[15:0];
            if (hitVinGain) vinGain_q <= vinGainNew[7:0];
            if (hitTherm) therm_q <= thermNew[7:0];
            if (hitFsr) fsr_q <= fsrNew[8:0]; // R09
            if (hitVinOfs) vinOfs_q <= vinOfsNew[10:0];
            // a bad phase code keeps the last good floor
            if (hitLp) lp_q <= phaseOk ? lpNew[7:0] : {lpNew[7:3], lp_q[2:0]}; // R15 R18
            if (hitCtrl) optoMode_q <= ctrlNew[vr_trim_pkg::CTRL_OPTO_BIT];
            if (hitMask) mask_q <= maskNew[vr_trim_pkg::EV_W-1:0];
        end
    end

    // working and stored monitor gain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imonGain_q <= '0;
            storedGain_q <= vr_trim_pkg::RST_STORED_GAIN;
            gainDirty_q <= 1'b0;
            loadPend_q <= 1'b1;
        end else if (ce) begin
            if (loadPend_q) begin
                imonGain_q <= storedGain_q + FACTORY_TRIM; // R13
                loadPend_q <= 1'b0;
            end else if (wr && hitImonGain) begin
                imonGain_q <= imonGainNew[7:0];
                gainDirty_q <= 1'b1;
            end else if (storeCmd && gainDirty_q) begin
                storedGain_q <= imonGain_q - FACTORY_TRIM; // R14
                gainDirty_q <= 1'b0;
            end
        end
    end

    // bus answer, status and interrupt
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            status_q <= '0;
            irq_q <= 1'b0;
        end else if (ce) begin
            ack_q <= req;
            rdat_q <= req ? rdMux : 32'h0000_0000;
            // a new event outranks a same-cycle clear
            status_q <= (status_q & ~((wr && hitStatus) ? clrWord[3:0] : 4'h0)) | events;
            irq_q <= |(status_q & mask_q);
        end
    end

    // offset filter and overcurrent mask
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filt_q <= '0;
            dvcPrev_q <= 1'b0;
            maskCnt_q <= '0;
        end else if (ce) begin
            filt_q <= filt_q + stepVal; // R03
            dvcPrev_q <= dvcActive;
            if (dvcEnd) maskCnt_q <= maskCyc; // R04
            else if (maskCnt_q != '0) maskCnt_q <= maskCnt_q - 1'b1;
        end
    end

    // coefficient refresh on every write that may touch tau
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coef_q <= vr_trim_pkg::COEF_W'(2 ** vr_trim_pkg::COEF_FRAC);
            coefPend_q <= 1'b1;
            coefStart_q <= 1'b0;
        end else if (ce) begin
            coefStart_q <= coefPend_q && !coefBus.busy && !coefStart_q;
            if (wrTau) coefPend_q <= 1'b1;
            else if (coefStart_q) coefPend_q <= 1'b0;
            if (coefBus.done) coef_q <= coefBus.quot[vr_trim_pkg::COEF_W-1:0]; // R03
        end
    end

    // telemetry outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vinCorr <= '0;
            imonCorr <= '0;
            ioutCorr <= '0;
            thermStart_q <= 1'b0;
            thermNum_q <= '0;
            thermDen_q <= '0;
        end else if (ce) begin
            if (vinValid) vinCorr <= optoMode_q ? vinSat : vinRaw; // R05 R11
            if (imonValid) imonCorr <= imSat; // R12
            thermStart_q <= ioutValid && !thermBus.busy && !thermStart_q;
            if (ioutValid && !thermBus.busy && !thermStart_q) begin
                thermNum_q <= TNW'(ioutRaw) * TNW'(vr_trim_pkg::THERM_DEN_BASE);
                thermDen_q <= TDW'(vr_trim_pkg::THERM_DEN_BASE)
                              + TDW'(vr_trim_pkg::ALPHA_NUM) * TDW'(tClamp); // R07
            end
            if (thermBus.done) ioutCorr <= thermBus.quot[IOUT_W-1:0];
        end
    end

    // hiccup retry
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            retry_q <= RUN;
            retryCnt_q <= '0;
            faultPrev_q <= 1'b0;
            faultFlag <= 1'b0;
            retryStart <= 1'b0;
        end else if (ce) begin
            faultPrev_q <= faultIn;
            retryStart <= retryFire;
            unique case (retry_q)
                RUN: begin
                    if (faultRise) faultFlag <= 1'b1;
                    if (faultRise && hiccupOn) begin // R16
                        retry_q <= WAIT_RETRY;
                        retryCnt_q <= HW'(HICCUP_CYCLES);
                    end
                end
                WAIT_RETRY: begin
                    retryCnt_q <= retryCnt_q - 1'b1;
                    if (retryFire) begin
                        retry_q <= RUN;
                        faultFlag <= 1'b0; // R17
                    end
                end
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq = irq_q;
    assign refOffset = filt_q;
    assign ocMask = maskCnt_q != '0;
    assign ioutFullScale = fsr_q;
    assign lowPowerPhases = lp_q[vr_trim_pkg::LP_PHASE_W-1:0];
endmodule // vr_trim_and_dynamic_voltage_change_offset_config
`default_nettype wire

/* File: rtl/vr_trim_pkg.sv */
// constants for the regulator trim and transition-offset block
// assumes a 20 MHz clock and a classic wishbone bus, word index = byte address / 4
package vr_trim_pkg;
    localparam int ADR_W = 18;
    localparam logic [15:0] IDX_DVC_LO = 16'hB00E;
    localparam logic [15:0] IDX_DVC_HI = 16'hB00F;
    localparam logic [15:0] IDX_VIN_GAIN = 16'hB018;
    localparam logic [15:0] IDX_THERM = 16'hB01A;
    localparam logic [15:0] IDX_FSR = 16'hB01B;
    localparam logic [15:0] IDX_VIN_OFS = 16'hB027;
    localparam logic [15:0] IDX_CURRENT_MONITOR_GAIN = 16'hB029;
    localparam logic [15:0] IDX_LP = 16'hB02B;
    localparam logic [15:0] IDX_CTRL = 16'hB0F0;
    localparam logic [15:0] IDX_STATUS = 16'hB0F1;
    localparam logic [15:0] IDX_MASK = 16'hB0F2;
    localparam logic [15:0] IDX_STORED = 16'hB0F3;
    localparam logic [15:0] IDX_COEF = 16'hB0F4;
    localparam int RISE_FAST_LSB = 42;
    localparam int RISE_SLOW_LSB = 36;
    localparam int FALL_FAST_LSB = 30;
    localparam int FALL_SLOW_LSB = 24;
    localparam int OFS_W = 6;
    localparam int TAU_LSB = 10;
    localparam int TAU_W = 14;
    localparam int OCM_LSB = 0;
    localparam int OCM_W = 10;
    localparam int VIN_SIGN_BIT = 10;
    localparam int VIN_MAG_W = 10;
    localparam int LP_PHASE_W = 3;
    localparam int LP_HICCUP_BIT = 7;
    localparam int CTRL_OPTO_BIT = 0;
    localparam int CTRL_STORE_BIT = 1;
    localparam int EV_DVC_END = 0;
    localparam int EV_RETRY = 1;
    localparam int EV_STORED = 2;
    localparam int EV_BAD_PHASE = 3;
    localparam int EV_W = 4;
    localparam logic [47:0] RST_DVC = 48'h0000_0000_0000;
    localparam logic [7:0] RST_VIN_GAIN = 8'h80;
    localparam logic [7:0] RST_THERM = 8'h80;
    localparam logic [8:0] RST_FSR = 9'h100;
    localparam logic [10:0] RST_VIN_OFS = 11'h400;
    localparam logic [7:0] RST_STORED_GAIN = 8'h80;
    localparam logic [7:0] RST_LP = 8'h01;
    localparam logic [2:0] PHASE_MIN = 3'h1;
    localparam logic [2:0] PHASE_MAX = 3'h6;
    localparam int COEF_FRAC = 14;
    localparam int COEF_W = 15;
    localparam int COEF_NUM = 25 * (2 ** COEF_FRAC);
    localparam int COEF_BASE_NS = 25;
    localparam int CLK_NS = 50;
    localparam int MASK_STEP_NS = 100;
    localparam int MASK_FIXED_NS = 25;
    localparam int MASK_CNT_W = 12;
    localparam int GAIN_SHIFT = 7;
    localparam int ALPHA_NUM = 39;
    localparam int ALPHA_DEN = 10000;
    localparam int TCOMP_UNITY = 128;
    localparam int THERM_DEN_BASE = ALPHA_DEN * TCOMP_UNITY;
    // keeps 1/(1+x) at or above 0.67, i.e. x <= 33/67
    localparam int THERM_PROD_MAX = (THERM_DEN_BASE * 33) / (ALPHA_NUM * 67);
    localparam int HICCUP_NS = 1000000;
    localparam int HICCUP_CYC = HICCUP_NS / CLK_NS;
endpackage
